// [pkg/occ_pkg.sv]
// occ_pkg: register map, field layout and reset values for the output
// channel configuration block; shared by the top module and the mapper
package occ_pkg;

	// register port geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_CH = 8;
	localparam int OC_W   = 6;

	// register offsets (byte addresses, one aligned word each)
	localparam logic [7:0] ADDR_CH_LAST = 8'h1C;
	localparam logic [7:0] ADDR_MODE    = 8'h20;
	localparam logic [7:0] ADDR_FAULT   = 8'h24;
	localparam logic [7:0] ADDR_STATUS  = 8'h28;

	// per-channel configuration word
	localparam int CFG_SIDE_BIT = 0;
	localparam int CFG_TYPE_BIT = 1;
	localparam int CFG_OC_LSB   = 2;
	localparam int CFG_W        = 8;

	// mode register
	localparam int MODE_PH_A_BIT = 0;
	localparam int MODE_PH_B_BIT = 1;
	localparam int MODE_BR_A_BIT = 2;
	localparam int MODE_BR_B_BIT = 3;
	localparam int MODE_W        = 4;

	// reset values
	localparam logic [7:0] CFG_RESET   = 8'h00;
	localparam logic [3:0] MODE_RESET  = 4'h0;
	localparam logic [7:0] FAULT_RESET = 8'h00;
	localparam logic [7:0] GATE_RESET  = 8'h00;

	// pin synchroniser: {trip[7:0], off_low_n, off_high, permit, drive_n[7:0]}
	localparam int          SYNC_W     = 19;
	localparam logic [18:0] SYNC_RESET = 19'h0_04FF;

endpackage

// [pkg/occ_map_if.sv]
// occ_map_if: carries raw channel bits and mode selects to the channel
// mapper and the effective side and transistor type back; combinational
`timescale 1ns/1ps
interface occ_map_if;
	logic [7:0] side_bit;
	logic [7:0] type_bit;
	logic [3:0] mode;
	logic [7:0] eff_hs;
	logic [7:0] eff_p;
	logic       br_a;
	logic       br_b;
	logic       ph_a;
	logic       ph_b;

	modport cfg (
		output side_bit,
		output type_bit,
		output mode,
		input  eff_hs,
		input  eff_p,
		input  br_a,
		input  br_b,
		input  ph_a,
		input  ph_b
	);

	modport mapper (
		input  side_bit,
		input  type_bit,
		input  mode,
		output eff_hs,
		output eff_p,
		output br_a,
		output br_b,
		output ph_a,
		output ph_b
	);
endinterface

// [src/occ_chan_map.sv]
// occ_chan_map: resolves pair and bridge modes into per-channel side and
// transistor type; purely combinational, fed from registered config
`timescale 1ns/1ps
module occ_chan_map (
	occ_map_if.mapper m
);
	logic [7:0] hs;
	logic       bra;
	logic       brb;
	logic       pha;
	logic       phb;

	always_comb begin
		bra = m.mode[occ_pkg::MODE_BR_A_BIT];
		brb = m.mode[occ_pkg::MODE_BR_B_BIT];
		pha = m.mode[occ_pkg::MODE_PH_A_BIT] & ~bra;
		phb = m.mode[occ_pkg::MODE_PH_B_BIT] & ~bra;
		hs = m.side_bit;
		if (pha) begin
			hs[0] = 1'b1;
			hs[3] = 1'b0;
		end
		if (phb) begin
			hs[1] = 1'b1;
			hs[2] = 1'b0;
		end
		if (bra) begin
			hs[1:0] = 2'b11;
			hs[3:2] = 2'b00;
		end
		if (brb) begin
			hs[5:4] = 2'b11;
			hs[7:6] = 2'b00;
		end
		m.eff_hs = hs;
		m.eff_p  = m.type_bit & hs;
		m.br_a   = bra;
		m.br_b   = brb;
		m.ph_a   = pha;
		m.ph_b   = phb;
	end
endmodule

// [src/occ_chan_cfg.sv]
// occ_chan_cfg: eight-channel gate pre-driver configuration and gating
// assumes a synchronous register port master and asynchronous pin inputs
`timescale 1ns/1ps
module occ_chan_cfg (
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	// register port
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [31:0] reg_rdata_o,
	// controller pins
	input  wire logic [7:0]  channel_drive_n_i,
	input  wire logic        ch6_driver_permit_i,
	input  wire logic        external_off_high_i,
	input  wire logic        external_off_low_n_i,
	// overcurrent comparators
	input  wire logic [7:0]  oc_trip_i,
	output logic      [47:0] oc_threshold_o,
	// gate driver controls
	output logic      [7:0]  gate_on_o,
	output logic      [7:0]  gate_high_side_o,
	output logic      [7:0]  gate_p_type_o
);

	function automatic logic occ_is_chan(input logic [7:0] addr);
		return (addr <= occ_pkg::ADDR_CH_LAST) && (addr[1:0] == 2'b00);
	endfunction

	// legs in order {ls_b, ls_a, hs_b, hs_a}; a pulse idle or float leaves all off
	function automatic logic [3:0] occ_bridge_legs(input logic pulse_n,
		input logic dir, input logic float_n);
		logic [3:0] legs;
		legs = 4'h0;
		if (!pulse_n && float_n) begin
			legs = dir ? 4'h9 : 4'h6;
		end
		return legs;
	endfunction

	logic [occ_pkg::SYNC_W-1:0] sync_meta;
	logic [occ_pkg::SYNC_W-1:0] sync_stable;
	logic [occ_pkg::SYNC_W-1:0] pin_vec;
	logic [7:0]                 drive_n_s;
	logic                       permit_s;
	logic                       off_high_s;
	logic                       off_low_n_s;
	logic [7:0]                 trip_s;

	logic [7:0]  ch_cfg      [8];
	logic [7:0]  next_ch_cfg [8];
	logic [3:0]  mode_r;
	logic [3:0]  next_mode;
	logic [7:0]  fault;
	logic [7:0]  next_fault;
	logic [7:0]  clr;
	logic [31:0] next_rdata;
	logic [7:0]  next_gate;
	logic [7:0]  cmd;
	logic [7:0]  kill;
	logic        ext_off;
	logic [1:0]  limp_cmd;

	occ_map_if map_if ();

	occ_chan_map u_map (
		.m (map_if.mapper)
	);

	// pins cross in through two flops; only the second stage is read
	assign pin_vec = {oc_trip_i, external_off_low_n_i, external_off_high_i,
		ch6_driver_permit_i, channel_drive_n_i};

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			sync_meta   <= occ_pkg::SYNC_RESET;
			sync_stable <= occ_pkg::SYNC_RESET;
		end else begin
			sync_meta   <= pin_vec;
			sync_stable <= sync_meta;
		end
	end

	assign drive_n_s   = sync_stable[7:0];
	assign permit_s    = sync_stable[8];
	assign off_high_s  = sync_stable[9];
	assign off_low_n_s = sync_stable[10];
	assign trip_s      = sync_stable[18:11];

	always_comb begin
		for (int i = 0; i < occ_pkg::NUM_CH; i++) begin
			map_if.side_bit[i] = ch_cfg[i][occ_pkg::CFG_SIDE_BIT];
			map_if.type_bit[i] = ch_cfg[i][occ_pkg::CFG_TYPE_BIT];
			oc_threshold_o[i*occ_pkg::OC_W +: occ_pkg::OC_W] =
				ch_cfg[i][occ_pkg::CFG_OC_LSB +: occ_pkg::OC_W];
		end
		map_if.mode = mode_r;
	end

	// channel command from the pins
	always_comb begin
		cmd = ~drive_n_s;
		if (map_if.br_a) begin
			cmd[3:0] = occ_bridge_legs(drive_n_s[0], drive_n_s[1], drive_n_s[2]);
		end
		if (map_if.br_b) begin
			cmd[7:4] = occ_bridge_legs(drive_n_s[4], drive_n_s[5], drive_n_s[6]);
		end
		ext_off = off_high_s | ~off_low_n_s;
		kill    = 8'h00;
		if (ext_off) begin
			kill[5:0] = 6'h3F;
		end
		if (!permit_s) begin
			kill[5] = 1'b1;
		end
	end

	assign limp_cmd = cmd[7:6];

	// register port and fault latch
	always_comb begin
		for (int i = 0; i < occ_pkg::NUM_CH; i++) begin
			next_ch_cfg[i] = ch_cfg[i];
		end
		next_mode  = mode_r;
		next_rdata = 32'h0000_0000;
		clr        = 8'h00;
		if (reg_wr_i) begin
			if (occ_is_chan(reg_addr_i)) begin
				next_ch_cfg[reg_addr_i[4:2]] = reg_wdata_i[occ_pkg::CFG_W-1:0];
			end else if (reg_addr_i == occ_pkg::ADDR_MODE) begin
				next_mode = reg_wdata_i[occ_pkg::MODE_W-1:0];
			end
		end
		if (reg_rd_i) begin
			if (occ_is_chan(reg_addr_i)) begin
				next_rdata = {24'h00_0000, ch_cfg[reg_addr_i[4:2]]};
			end else if (reg_addr_i == occ_pkg::ADDR_MODE) begin
				next_rdata = {28'h000_0000, mode_r};
			end else if (reg_addr_i == occ_pkg::ADDR_FAULT) begin
				next_rdata = {24'h00_0000, fault};
				clr        = fault;
			end else if (reg_addr_i == occ_pkg::ADDR_STATUS) begin
				next_rdata = {8'h00, gate_on_o, gate_p_type_o, gate_high_side_o};
			end
		end
		next_fault = (fault & ~clr) | trip_s;
		next_gate  = cmd & ~kill & ~next_fault;
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			for (int i = 0; i < occ_pkg::NUM_CH; i++) begin
				ch_cfg[i] <= occ_pkg::CFG_RESET;
			end
			mode_r           <= occ_pkg::MODE_RESET;
			fault            <= occ_pkg::FAULT_RESET;
			gate_on_o        <= occ_pkg::GATE_RESET;
			gate_high_side_o <= 8'h00;
			gate_p_type_o    <= 8'h00;
			reg_rdata_o      <= 32'h0000_0000;
		end else begin
			for (int i = 0; i < occ_pkg::NUM_CH; i++) begin
				ch_cfg[i] <= next_ch_cfg[i];
			end
			mode_r           <= next_mode;
			fault            <= next_fault;
			gate_on_o        <= next_gate;
			gate_high_side_o <= map_if.eff_hs;
			gate_p_type_o    <= map_if.eff_p;
			reg_rdata_o      <= next_rdata;
		end
	end

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (reset_i);

	a_mode_read_data: assert property (
		(reg_rd_i && reg_addr_i == occ_pkg::ADDR_MODE) |=>
			reg_rdata_o == {28'h000_0000, $past(mode_r)})
		else $error("mode read data wrong");

	a_ptype_high_only: assert property (
		(gate_p_type_o & ~gate_high_side_o) == 8'h00)
		else $error("p type on low side channel");

	a_pair_a_sides: assert property (
		(mode_r[occ_pkg::MODE_PH_A_BIT] && !mode_r[occ_pkg::MODE_BR_A_BIT]) |=>
			(gate_high_side_o[0] && !gate_high_side_o[3]))
		else $error("pair a sides not forced");

	a_pair_b_sides: assert property (
		(mode_r[occ_pkg::MODE_PH_B_BIT] && !mode_r[occ_pkg::MODE_BR_A_BIT]) |=>
			(gate_high_side_o[1] && !gate_high_side_o[2]))
		else $error("pair b sides not forced");

	a_bridge_a_sides: assert property (
		mode_r[occ_pkg::MODE_BR_A_BIT] |=> gate_high_side_o[3:0] == 4'h3)
		else $error("bridge a sides wrong");

	a_bridge_b_sides: assert property (
		mode_r[occ_pkg::MODE_BR_B_BIT] |=> gate_high_side_o[7:4] == 4'h3)
		else $error("bridge b sides wrong");

	a_ch6_permit_gate: assert property (
		!permit_s |=> !gate_on_o[5])
		else $error("channel 6 on without permit");

	a_ext_off_gate: assert property (
		ext_off |=> gate_on_o[5:0] == 6'h00)
		else $error("guarded channel on while disabled");

	a_limp_keep_run: assert property (
		(ext_off && trip_s[7:6] == 2'b00 && fault[7:6] == 2'b00) |=>
			gate_on_o[7:6] == $past(limp_cmd))
		else $error("limp channels affected by disable");

	a_trip_fast_off: assert property (
		(trip_s != 8'h00) |=> (gate_on_o & $past(trip_s)) == 8'h00)
		else $error("tripped channel still on");

	a_fault_held_read: assert property (
		(trip_s != 8'h00) |=> (fault & $past(trip_s)) == $past(trip_s) ##1
			(fault & $past(trip_s, 2)) == $past(trip_s, 2) || $past(reg_rd_i))
		else $error("fault lost before report");

	a_reset_all_off: assert property (@(posedge ref_clk_i) disable iff (1'b0)
		reset_i |=> (mode_r == 4'h0 && gate_on_o == 8'h00))
		else $error("state not cleared by reset");

	a_rdata_idle_zero: assert property (
		!reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
		else $error("read data not zero when idle");

	a_mode_write_lands: assert property (
		(reg_wr_i && reg_addr_i == occ_pkg::ADDR_MODE) |=>
			mode_r == $past(reg_wdata_i[occ_pkg::MODE_W-1:0]))
		else $error("mode write not taken");

	a_fault_read_data: assert property (
		(reg_rd_i && reg_addr_i == occ_pkg::ADDR_FAULT) |=>
			reg_rdata_o == {24'h00_0000, $past(fault)})
		else $error("fault read data wrong");

	a_plain_sides: assert property (
		(mode_r == 4'h0) |=> gate_high_side_o == $past(map_if.side_bit))
		else $error("plain channel side not from its bit");

	a_pair_a_type: assert property (
		(mode_r[occ_pkg::MODE_PH_A_BIT] && !mode_r[occ_pkg::MODE_BR_A_BIT]) |=>
			gate_p_type_o[0] == $past(map_if.type_bit[0]))
		else $error("pair a high side type wrong");

	a_bridge_b_type: assert property (
		mode_r[occ_pkg::MODE_BR_B_BIT] |=>
			gate_p_type_o[5:4] == $past(map_if.type_bit[5:4]) && gate_p_type_o[7:6] == 2'b00)
		else $error("bridge b transistor type wrong");

	a_fault_keeps_off: assert property (
		(gate_on_o & fault) == 8'h00)
		else $error("faulted channel driven");

	c_bridge_a_drive: cover property (map_if.br_a && gate_on_o[3:0] == 4'h9);
	c_both_pairs: cover property (map_if.ph_a && map_if.ph_b && gate_on_o != 8'h00);
	c_limp_while_off: cover property (ext_off && gate_on_o[7:6] != 2'b00);
	c_fault_readout: cover property (reg_rd_i && reg_addr_i == occ_pkg::ADDR_FAULT
		&& trip_s != 8'h00);
	c_bridge_b_float: cover property (map_if.br_b && !drive_n_s[4] && !drive_n_s[6]);

endmodule

// [testbench/occ_mcu_model.sv]
// occ_mcu_model: controller beside the channel block, masters the register
// port and drives the on/off, permit and disable pins
// assumes the bench calls its tasks from one process only
`timescale 1ns/1ps
module occ_mcu_model (
	// clock
	input  wire logic        ref_clk_i,
	// register port
	input  wire logic [31:0] reg_rdata_i,
	output logic      [7:0]  reg_addr_o,
	output logic      [31:0] reg_wdata_o,
	output logic             reg_wr_o,
	output logic             reg_rd_o,
	// pins
	output logic      [7:0]  channel_drive_n_o,
	output logic             ch6_driver_permit_o,
	output logic             external_off_high_o,
	output logic             external_off_low_n_o
);
	// pins idle at their pulled-up or inactive levels
	initial begin
		reg_addr_o           = 8'h00;
		reg_wdata_o          = 32'h0000_0000;
		reg_wr_o             = 1'b0;
		reg_rd_o             = 1'b0;
		channel_drive_n_o    = 8'hFF;
		ch6_driver_permit_o  = 1'b0;
		external_off_high_o  = 1'b0;
		external_off_low_n_o = 1'b1;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		reg_addr_o  <= a;
		reg_wdata_o <= d;
		reg_wr_o    <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_o    <= 1'b0;
	endtask

	// data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk_i);
		reg_addr_o <= a;
		reg_rd_o   <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd_o   <= 1'b0;
		#1;
		d = reg_rdata_i;
	endtask

	// active-low drive, active-high permit, and active-high oh / active-low ol_n disable pins
	task automatic pins(input logic [7:0] n, input logic pm, input logic oh, input logic ol_n);
		@(posedge ref_clk_i);
		channel_drive_n_o    <= n;
		ch6_driver_permit_o  <= pm;
		external_off_high_o  <= oh;
		external_off_low_n_o <= ol_n;
	endtask
endmodule

// [testbench/tb_occ_chan_cfg.sv]
// tb_occ_chan_cfg: self-checking bench for the channel configuration block
// assumes 40 MHz clock and the controller model on the far side
`timescale 1ns/1ps
module tb_occ_chan_cfg;
	logic        ref_clk_i;
	logic        reset_i;
	logic [7:0]  reg_addr_i;
	logic [31:0] reg_wdata_i;
	logic        reg_wr_i;
	logic        reg_rd_i;
	logic [31:0] reg_rdata_o;
	logic [7:0]  channel_drive_n_i;
	logic        ch6_driver_permit_i;
	logic        external_off_high_i;
	logic        external_off_low_n_i;
	logic [7:0]  oc_trip_i;
	logic [47:0] oc_threshold_o;
	logic [7:0]  gate_on_o;
	logic [7:0]  gate_high_side_o;
	logic [7:0]  gate_p_type_o;
	logic [31:0] rv;
	int          num_errors;
	int          comparisons;

	occ_chan_cfg dut_u (
		.ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .channel_drive_n_i(channel_drive_n_i),
		.ch6_driver_permit_i(ch6_driver_permit_i), .external_off_high_i(external_off_high_i),
		.external_off_low_n_i(external_off_low_n_i), .oc_trip_i(oc_trip_i),
		.oc_threshold_o(oc_threshold_o), .gate_on_o(gate_on_o),
		.gate_high_side_o(gate_high_side_o), .gate_p_type_o(gate_p_type_o));

	occ_mcu_model mcu_u (
		.ref_clk_i(ref_clk_i), .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i),
		.reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
		.channel_drive_n_o(channel_drive_n_i), .ch6_driver_permit_o(ch6_driver_permit_i),
		.external_off_high_o(external_off_high_i), .external_off_low_n_o(external_off_low_n_i));

	initial ref_clk_i = 1'b0;
	always #12.5 ref_clk_i = ~ref_clk_i;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// pin changes need two sync edges and one output edge
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask

	task automatic summarize();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic t_reset();
		chk({24'h0, gate_on_o}, 32'h0000_0000);
		mcu_u.rd(8'h20, rv);
		chk(rv, 32'h0000_0000);
		mcu_u.rd(8'h30, rv);
		chk(rv, 32'h0000_0000);
	endtask

	task automatic t_plain();
		mcu_u.wr(8'h00, 32'h0000_0003);
		mcu_u.wr(8'h08, 32'h0000_0002);
		mcu_u.wr(8'h04, 32'h0000_00A8);
		settle(3);
		chk({26'h0, gate_high_side_o[2:0], gate_p_type_o[2:0]}, 32'h0000_0009);
		chk({24'h0, gate_p_type_o}, 32'h0000_0001);
		chk({26'h0, oc_threshold_o[11:6]}, 32'h0000_002A);
		mcu_u.rd(8'h28, rv);
		chk({16'h0, rv[15:0]}, 32'h0000_0101);
		mcu_u.pins(8'h3E, 1'b0, 1'b0, 1'b1);
		settle(4);
		chk({24'h0, gate_on_o}, 32'h0000_00C1);
	endtask

	task automatic t_disable();
		mcu_u.pins(8'h1E, 1'b1, 1'b0, 1'b1);
		settle(4);
		chk({24'h0, gate_on_o}, 32'h0000_00E1);
		mcu_u.pins(8'h1E, 1'b0, 1'b0, 1'b1);
		settle(4);
		chk({24'h0, gate_on_o}, 32'h0000_00C1);
		mcu_u.pins(8'h1E, 1'b1, 1'b1, 1'b1);
		settle(4);
		chk({24'h0, gate_on_o}, 32'h0000_00C0);
		mcu_u.pins(8'h1E, 1'b1, 1'b0, 1'b0);
		settle(4);
		chk({24'h0, gate_on_o}, 32'h0000_00C0);
		mcu_u.pins(8'hFF, 1'b0, 1'b0, 1'b1);
		settle(4);
	endtask

	task automatic t_modes();
		mcu_u.wr(8'h00, 32'h0000_0000);
		mcu_u.wr(8'h0C, 32'h0000_0001);
		mcu_u.wr(8'h20, 32'h0000_0001);
		settle(3);
		chk({24'h0, gate_high_side_o}, 32'h0000_0001);
		mcu_u.wr(8'h00, 32'h0000_0002);
		mcu_u.wr(8'h20, 32'h0000_0003);
		settle(3);
		chk({24'h0, gate_high_side_o}, 32'h0000_0003);
		chk({24'h0, gate_p_type_o}, 32'h0000_0001);
		mcu_u.wr(8'h20, 32'h0000_0005);
		settle(3);
		chk({24'h0, gate_high_side_o}, 32'h0000_0003);
		mcu_u.wr(8'h20, 32'h0000_000C);
		settle(3);
		chk({24'h0, gate_high_side_o}, 32'h0000_0033);
		chk({24'h0, gate_p_type_o}, 32'h0000_0001);
		mcu_u.pins(8'h66, 1'b1, 1'b0, 1'b1);
		settle(4);
		chk({24'h0, gate_on_o}, 32'h0000_0099);
		mcu_u.pins(8'h44, 1'b1, 1'b0, 1'b1);
		settle(4);
		chk({24'h0, gate_on_o}, 32'h0000_0066);
		mcu_u.pins(8'h45, 1'b1, 1'b0, 1'b1);
		settle(4);
		chk({24'h0, gate_on_o}, 32'h0000_0060);
		mcu_u.pins(8'h04, 1'b1, 1'b0, 1'b1);
		settle(4);
		chk({24'h0, gate_on_o}, 32'h0000_0006);
		mcu_u.pins(8'hFF, 1'b0, 1'b0, 1'b1);
		mcu_u.wr(8'h20, 32'h0000_0000);
		settle(4);
		chk({24'h0, gate_high_side_o}, 32'h0000_0008);
	endtask

	task automatic t_fault();
		mcu_u.pins(8'hFE, 1'b0, 1'b0, 1'b1);
		settle(4);
		chk({24'h0, gate_on_o}, 32'h0000_0001);
		@(posedge ref_clk_i);
		oc_trip_i <= 8'h01;
		settle(4);
		chk({24'h0, gate_on_o}, 32'h0000_0000);
		@(posedge ref_clk_i);
		oc_trip_i <= 8'h00;
		settle(4);
		chk({24'h0, gate_on_o}, 32'h0000_0000);
		mcu_u.rd(8'h24, rv);
		chk(rv, 32'h0000_0001);
		settle(4);
		chk({24'h0, gate_on_o}, 32'h0000_0001);
		mcu_u.rd(8'h24, rv);
		chk(rv, 32'h0000_0000);
	endtask

	initial begin
		#(25ns * 5000);
		num_errors++;
		summarize();
	end

	initial begin
		num_errors  = 0;
		comparisons = 0;
		reset_i     = 1'b1;
		oc_trip_i   = 8'h00;
		repeat (12) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		settle(2);
		t_reset();
		t_plain();
		t_disable();
		t_modes();
		t_fault();
		summarize();
	end
endmodule
